//--- srm_rx_slot_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "srm_cfg.svh"

module srm_rx_slot_map
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // register access from the control interface
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_we,
  input  wire logic                    reg_re,
  output logic      [7:0]              reg_rdata,
  // slot stream from the second serial port receiver
  input  wire logic                    frame_start,
  input  wire logic                    slot_valid,
  input  wire logic                    tdm_mode,
  input  wire logic                    right_half,
  input  wire logic [4:0]              slot_num,
  input  wire logic [31:0]             slot_data,
  // routed samples, one entry per channel 6, 7, 8
  output logic      [2:0][31:0]        rx_data,
  output logic      [2:0]              dac_valid,
  output logic      [2:0]              loop_valid,
  output logic      [2:0]              link_valid
);
  import srm_pkg::*;

  localparam srm_top_state_t RST_S = {
    srm_map_t'(`SRM_CH8_RST), srm_map_t'(`SRM_CH7_RST), srm_map_t'(`SRM_CH6_RST),
    srm_map_t'(`SRM_CH8_RST), srm_map_t'(`SRM_CH7_RST), srm_map_t'(`SRM_CH6_RST),
    8'h00
  };

  srm_top_state_t s_q;
  srm_top_state_t s_d;
  logic [4:0]     slot_code;
  srm_map_t [2:0] use_map;

  // two-channel formats count 0..15 per half; right half adds the base
  assign slot_code = tdm_mode ? slot_num
                              : ((right_half ? `SRM_RIGHT_BASE : 5'h00) | {1'b0, slot_num[3:0]});

  // at a frame start the pending mapping already governs that frame
  assign use_map = frame_start ? s_q.shadow : s_q.active;

  always_comb
  begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    for (int i = 0; i < `SRM_CHANNELS; i++)
    begin
      if (reg_we && reg_addr == (`SRM_CH6_OFS + 8'(i)))
        s_d.shadow[i] = srm_map_t'({1'b0, reg_wdata[`SRM_SRC_MSB:`SRM_SLOT_LSB]});
      if (reg_re && reg_addr == (`SRM_CH6_OFS + 8'(i)))
        s_d.rdata = {1'b0, s_q.shadow[i][`SRM_SRC_MSB:`SRM_SLOT_LSB]};
    end
    if (frame_start)
      s_d.active = s_q.shadow;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      s_q <= RST_S;
    else
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;

  genvar g;
  generate
    for (g = 0; g < `SRM_CHANNELS; g++)
    begin : g_chan
      srm_chan_if ch_if ();
      assign ch_if.map        = use_map[g];
      assign ch_if.slot_valid = slot_valid;
      assign ch_if.slot_code  = slot_code;
      assign ch_if.slot_data  = slot_data;
      assign rx_data[g]       = ch_if.data;
      assign dac_valid[g]     = ch_if.dac_valid;
      assign loop_valid[g]    = ch_if.loop_valid;
      assign link_valid[g]    = ch_if.link_valid;

      srm_chan_route u_route
      (
        .ref_clk (ref_clk),
        .reset   (reset),
        .ch      (ch_if.chan)
      );
    end
  endgenerate

  // a write, one cycle without a write, then a read of the same register
  sequence write_then_read_s(logic [7:0] a);
    (reg_we && reg_addr == a) ##1 !reg_we ##1 (reg_re && !reg_we && reg_addr == a);
  endsequence

  rsvd_reads_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    reg_re |=> reg_rdata[`SRM_RSVD_BIT] == 1'b0)
    else $error("reserved bit read back as one");

  ch6_reset_val_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(reset) |-> s_q.shadow[0] == srm_map_t'(8'h05) && s_q.active[0] == srm_map_t'(8'h05))
    else $error("channel 6 map wrong after reset");

  ch7_reset_val_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(reset) |-> s_q.shadow[1] == srm_map_t'(8'h06))
    else $error("channel 7 map wrong after reset");

  ch8_reset_val_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(reset) |-> s_q.shadow[2] == srm_map_t'(8'h07))
    else $error("channel 8 map wrong after reset");

  ch8_write_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    write_then_read_s(8'h2f) |=> reg_rdata[7] == 1'b0 && reg_rdata[6:0] == $past(reg_wdata[6:0], 3))
    else $error("channel 8 readback differs from write");

  map_holds_frame_a: assert property (@(posedge ref_clk) disable iff (reset)
    !frame_start |=> s_q.active == $past(s_q.active))
    else $error("mapping changed inside a frame");

  map_loads_frame_a: assert property (@(posedge ref_clk) disable iff (reset)
    frame_start |=> s_q.active == $past(s_q.shadow))
    else $error("mapping not taken at frame start");

  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_re && reg_addr < 8'h2d) |=> reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");

endmodule // srm_rx_slot_map

`default_nettype wire

//--- srm_cfg.svh
`ifndef SRM_CFG_SVH
`define SRM_CFG_SVH

// register offsets on the control interface
`define SRM_CH6_OFS     8'h2d
`define SRM_CH7_OFS     8'h2e
`define SRM_CH8_OFS     8'h2f

// reset values
`define SRM_CH6_RST     8'h05
`define SRM_CH7_RST     8'h06
`define SRM_CH8_RST     8'h07

// field positions inside a mapping register
`define SRM_RSVD_BIT    7
`define SRM_SRC_MSB     6
`define SRM_SRC_LSB     5
`define SRM_SLOT_MSB    4
`define SRM_SLOT_LSB    0

// slot codes at or above this value pick the right half in two-channel formats
`define SRM_RIGHT_BASE  5'h10

// widths
`define SRM_CHANNELS    3
`define SRM_DATA_W      32

`endif

//--- srm_pkg.sv
package srm_pkg;

  // channel source selector, values 0 to 3 in declaration order
  typedef enum logic [1:0] {
    SRM_SRC_OFF,
    SRM_SRC_DAC,
    SRM_SRC_LOOP,
    SRM_SRC_LINK
  } srm_src_t;

  // one mapping register as stored
  typedef struct packed {
    logic     rsvd;
    srm_src_t src;
    logic [4:0] slot;
  } srm_map_t;

  // whole state of the register block
  typedef struct packed {
    srm_map_t [2:0] shadow;
    srm_map_t [2:0] active;
    logic [7:0]     rdata;
  } srm_top_state_t;

  // whole state of one channel router
  typedef struct packed {
    logic [31:0] data;
    logic        dac_valid;
    logic        loop_valid;
    logic        link_valid;
  } srm_chan_state_t;

endpackage

//--- srm_chan_if.sv
`timescale 1ns/1ps
`default_nettype none

interface srm_chan_if;
  import srm_pkg::*;
  srm_map_t    map;
  logic        slot_valid;
  logic [4:0]  slot_code;
  logic [31:0] slot_data;
  logic [31:0] data;
  logic        dac_valid;
  logic        loop_valid;
  logic        link_valid;

  modport ctl  (output map, slot_valid, slot_code, slot_data,
                input  data, dac_valid, loop_valid, link_valid);
  modport chan (input  map, slot_valid, slot_code, slot_data,
                output data, dac_valid, loop_valid, link_valid);
endinterface

`default_nettype wire

//--- srm_chan_route.sv
`timescale 1ns/1ps
`default_nettype none
`include "srm_cfg.svh"

module srm_chan_route
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // mapping and slot stream
  srm_chan_if.chan  ch
);
  import srm_pkg::*;

  srm_chan_state_t s_q;
  srm_chan_state_t s_d;
  logic            hit;

  // the slot code already carries the half in bit 4 for two-channel formats
  assign hit = ch.slot_valid && (ch.slot_code == ch.map.slot);

  always_comb
  begin
    s_d            = s_q;
    s_d.dac_valid  = 1'b0;
    s_d.loop_valid = 1'b0;
    s_d.link_valid = 1'b0;
    if (hit)
    begin
      case (ch.map.src)
        SRM_SRC_OFF:  s_d = s_d;
        SRM_SRC_DAC:
        begin
          s_d.data      = ch.slot_data;
          s_d.dac_valid = 1'b1;
        end
        SRM_SRC_LOOP:
        begin
          s_d.data       = ch.slot_data;
          s_d.loop_valid = 1'b1;
        end
        SRM_SRC_LINK:
        begin
          s_d.data       = ch.slot_data;
          s_d.link_valid = 1'b1;
        end
        default:      s_d = s_d;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ch.data       = s_q.data;
  assign ch.dac_valid  = s_q.dac_valid;
  assign ch.loop_valid = s_q.loop_valid;
  assign ch.link_valid = s_q.link_valid;

  sequence slot_hit_s(srm_src_t src);
    ch.slot_valid && ch.slot_code == ch.map.slot && ch.map.src == src;
  endsequence

  off_no_accept_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ch.slot_valid && ch.map.src == SRM_SRC_OFF) |=> !(ch.dac_valid || ch.loop_valid || ch.link_valid))
    else $error("disabled channel produced a sample");

  dac_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    slot_hit_s(SRM_SRC_DAC) |=> ch.dac_valid && !ch.loop_valid && ch.data == $past(ch.slot_data))
    else $error("playback route missed its slot");

  loop_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    slot_hit_s(SRM_SRC_LOOP) |=> ch.loop_valid && !ch.dac_valid && ch.data == $past(ch.slot_data))
    else $error("loopback route missed its slot");

  link_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    slot_hit_s(SRM_SRC_LINK) |=> ch.link_valid && !ch.dac_valid && ch.data == $past(ch.slot_data))
    else $error("companion route missed its slot");

  slot_match_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ch.dac_valid || ch.loop_valid || ch.link_valid) |-> $past(ch.slot_code) == $past(ch.map.slot))
    else $error("sample taken from the wrong slot");

endmodule // srm_chan_route

`default_nettype wire

//--- srm_frame_src.sv
`timescale 1ns/1ps
`default_nettype none

module srm_frame_src
(
  // clock
  input  wire logic   ref_clk,
  // slot stream towards the device
  output logic        frame_start,
  output logic        slot_valid,
  output logic        tdm_mode,
  output logic        right_half,
  output logic [4:0]  slot_num,
  output logic [31:0] slot_data
);
  initial
  begin
    frame_start = 1'b0;
    slot_valid  = 1'b0;
    tdm_mode    = 1'b1;
    right_half  = 1'b0;
    slot_num    = 5'h00;
    slot_data   = 32'h00000000;
  end

  // one slot, optionally opening a frame; afterwards the lines carry junk, not the old slot
  task automatic send(input logic fs, input logic tdm, input logic rh, input logic [4:0] num,
                      input logic [31:0] d);
    @(posedge ref_clk);
    frame_start <= fs;
    slot_valid  <= 1'b1;
    tdm_mode    <= tdm;
    right_half  <= rh;
    slot_num    <= num;
    slot_data   <= d;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    slot_valid  <= 1'b0;
    right_half  <= ~rh;
    slot_num    <= ~num;
    slot_data   <= ~d;
  endtask
endmodule // srm_frame_src

`default_nettype wire

//--- srm_rx_slot_map_tb.sv
`timescale 1ns/1ps
`default_nettype none

module srm_rx_slot_map_tb;
  logic             ref_clk, reset, reg_we, reg_re;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata;
  logic             frame_start, slot_valid, tdm_mode, right_half;
  logic [4:0]       slot_num;
  logic [31:0]      slot_data;
  logic [2:0][31:0] rx_data;
  logic [2:0]       dac_valid, loop_valid, link_valid;
  logic [8:0]       exp_v;
  logic [31:0]      d;
  int               err_total, n_tests;

  srm_rx_slot_map u_srm_rx_slot_map (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .slot_valid(slot_valid), .tdm_mode(tdm_mode), .right_half(right_half),
    .slot_num(slot_num), .slot_data(slot_data), .rx_data(rx_data), .dac_valid(dac_valid),
    .loop_valid(loop_valid), .link_valid(link_valid));

  srm_frame_src u_src (.ref_clk(ref_clk), .frame_start(frame_start), .slot_valid(slot_valid),
    .tdm_mode(tdm_mode), .right_half(right_half), .slot_num(slot_num), .slot_data(slot_data));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= wd;
    reg_we    <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 check({24'h0, reg_rdata}, {24'h0, e});
  endtask

  // one slot, then the valid pulses of all channels as {dac, loop, link}
  task automatic slot_chk(input logic fs, input logic tdm, input logic rh, input logic [4:0] num,
                          input logic [31:0] sd, input logic [8:0] ev);
    u_src.send(fs, tdm, rh, num, sd);
    #1 check({23'h0, dac_valid, loop_valid, link_valid}, {23'h0, ev});
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end

  initial
  begin
    err_total = 0;
    n_tests   = 0;
    reset     = 1'b1;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(8'h2d, 8'h05);
    rd_chk(8'h2e, 8'h06);
    rd_chk(8'h2f, 8'h07);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h2c, 8'h00);
    // reserved bit set on write must read back clear
    reg_write(8'h2f, 8'he3);
    rd_chk(8'h2f, 8'h63);
    // new map stays pending until a frame opens
    reg_write(8'h2d, 8'h25);
    slot_chk(1'b0, 1'b1, 1'b0, 5'h05, 32'h0000a5a5, 9'h000);
    slot_chk(1'b1, 1'b1, 1'b0, 5'h05, 32'h0000a5a5, 9'h040);
    check(rx_data[0], 32'h0000a5a5);
    // every source code on every channel, each channel on its own slot
    for (int c = 0; c < 3; c++)
      for (int s = 0; s < 4; s++)
      begin
        d = 32'hd0000000 + 32'(c * 4 + s);
        reg_write(8'(8'h2d + c), {1'b0, 2'(s), 5'(8 + c)});
        exp_v = {(s == 1) ? 3'(1 << c) : 3'h0, (s == 2) ? 3'(1 << c) : 3'h0, (s == 3) ? 3'(1 << c) : 3'h0};
        slot_chk(1'b1, 1'b1, 1'b0, 5'(8 + c), d, exp_v);
        if (s != 0)
          check(rx_data[c], d);
      end
    // slot decoding at the edges of the left and right halves
    reg_write(8'h2d, 8'h6f);
    reg_write(8'h2e, 8'h71);
    reg_write(8'h2f, 8'h7f);
    slot_chk(1'b1, 1'b0, 1'b0, 5'h1f, 32'h11111111, 9'h001);
    slot_chk(1'b0, 1'b0, 1'b1, 5'h01, 32'h22222222, 9'h002);
    slot_chk(1'b0, 1'b1, 1'b0, 5'h1f, 32'h33333333, 9'h004);
    slot_chk(1'b0, 1'b1, 1'b0, 5'h0f, 32'h44444444, 9'h001);
    slot_chk(1'b0, 1'b0, 1'b1, 5'h0f, 32'h55555555, 9'h004);
    slot_chk(1'b0, 1'b1, 1'b0, 5'h11, 32'h66666666, 9'h002);
    check(rx_data[1], 32'h66666666);
    print_verdict();
  end
endmodule // srm_rx_slot_map_tb

`default_nettype wire
